// ===== core/edu_pkg.sv
// exception dispatch unit: shared constants, types and field layout
package edu_pkg;
  // opcode bytes of the explicit trap instructions
  localparam logic [7:0] OPC_VEC_CALL = 8'hCD;
  localparam logic [7:0] OPC_OVF_TRAP = 8'hCE;
  localparam logic [7:0] OPC_BRK_CALL = 8'hCC;
  localparam logic [7:0] OPC_DBG_CALL = 8'hF1;
  // exception vectors
  localparam logic [7:0] VEC_DEBUG     = 8'h01;
  localparam logic [7:0] VEC_BREAK     = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW  = 8'h04;
  localparam logic [7:0] VEC_RANGE     = 8'h05;
  localparam logic [7:0] VEC_LEGACY_FP = 8'h10;
  localparam logic [7:0] VEC_VECTOR_FP = 8'h13;
  localparam logic [7:0] VEC_MASK_MIN  = 8'h20;
  // register port byte addresses and fields
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam int         CTRL_REAL_BIT = 0;
  localparam int         CTRL_LONG_BIT = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h0;
  // interrupt enable position inside flags_word
  localparam int         FLAGS_IF_BIT  = 9;
  // stack slot sizes in bytes per mode
  localparam logic [3:0] PUSH_REAL     = 4'h2;
  localparam logic [3:0] PUSH_PROT     = 4'h4;
  localparam logic [3:0] PUSH_LONG     = 4'h8;
  // table entry size as a shift of the vector
  localparam int         TBL_SH_REAL   = 2;
  localparam int         TBL_SH_PROT   = 3;
  localparam int         TBL_SH_LONG   = 4;
  localparam logic [15:0] NULL_SEL     = 16'h0000;
  localparam int         FRAME_SLOTS   = 6;
  // kinds of request from the decoder
  typedef enum logic [2:0] {
    OP_NONE, OP_TRAP, OP_RANGE, OP_FP, OP_FRAME, OP_RETURN
  } edu_op_type;
  // descriptor gate kinds
  typedef enum logic [1:0] {
    GATE_INTR, GATE_TRAP, GATE_TASK
  } edu_gate_kind_type;
  // one decoded request
  typedef struct packed {
    logic        valid;
    edu_op_type  kind;
    logic [7:0]  opcode;
    logic [7:0]  vector;
    logic        ovf;
    logic [31:0] operand;
    logic [31:0] lower;
    logic [31:0] upper;
    logic        err_valid;
    logic [31:0] err_code;
    logic [5:0]  fp_cond;
    logic        fp_packed;
    logic [15:0] storage;
    logic [7:0]  level;
  } edu_req_type;
  // architectural state of the running task
  typedef struct packed {
    logic [31:0] flags;
    logic [63:0] ip;
    logic [15:0] cs;
    logic [15:0] ss;
    logic [63:0] sp;
    logic [1:0]  priv;
  } edu_arch_type;
  // table entry as read back from memory
  typedef struct packed {
    edu_gate_kind_type kind;
    logic [15:0]       sel;
    logic [63:0]       offset;
    logic [1:0]        priv;
  } edu_gate_type;
endpackage

// ===== core/edu_dispatch.sv
// exception dispatch unit: trap decode, table fetch, frame push, load
//
// Overview of operation
// - task gate vector does implicit task switch
// - save interrupted state, restore on return
// - real mode indexes table, far calls entry
// - real mode pushes flags, cs, ip, error
// - only handler_return_op returns from handler
// - byte CD calls handler of given vector
// - byte CE traps only if overflow set
// - arithmetic overflow never raises vector 4 itself
// - byte CC always calls breakpoint handler
// - byte F1 always calls debug handler
// - range check raises vector 5 outside limits
// - no implicit bounds checks anywhere
// - six distinct floating-point conditions recognised
// - legacy fp condition raises legacy_fp_error
// - packed fp condition raises vector_fp_error
// - long mode table handlers run 64-bit code
// - long mode pushes are zero-extended 8 bytes
// - long mode always pushes stack selector, pointer
// - long mode privilege change nulls stack selector
// - frame nesting level limited to 0..31
// - frame first operand is bytes reserved
// - nesting level ignores privilege checks
// - interrupt gate clears interrupt enable flag
// - vectors 32..255 maskable, pin or call
`timescale 1ns/100ps
`default_nettype none
module edu_dispatch (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  // decoder request and external interrupt pin
  input  wire edu_pkg::edu_req_type  req,
  input  wire logic                  ext_intr,
  input  wire logic [7:0]            ext_vector,
  output logic                       ext_ack,
  output logic                       busy,
  // current architectural state
  input  wire edu_pkg::edu_arch_type arch,
  // descriptor table read
  output logic                       tbl_rd_en,
  output logic [63:0]                tbl_rd_addr,
  input  wire edu_pkg::edu_gate_type tbl_entry,
  // stack write path
  output logic                       push_en,
  output logic [63:0]                push_addr,
  output logic [63:0]                push_data,
  output logic [3:0]                 push_bytes,
  // handler load and task switch
  output logic                       handler_valid,
  output edu_pkg::edu_arch_type      handler_state,
  output logic                       handler_code64,
  output logic                       task_switch,
  output logic                       task_restore,
  output logic                       ret_valid,
  // frame setup result
  output logic                       frame_valid,
  output logic [63:0]                frame_sp,
  output logic [4:0]                 frame_level
);

  // dispatch states, gray along idle-fetch-wait-push-load
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT  = 3'b011,
    ST_PUSH  = 3'b010,
    ST_LOAD  = 3'b110
  } edu_state_type;

  edu_state_type         state_reg;      // dispatch sequencer
  logic [1:0]            ctrl_reg;       // mode bits from software
  logic [7:0]            vec_reg;        // vector being dispatched
  logic                  err_en_reg;     // error code slot wanted
  logic [31:0]           err_reg;        // error code to push
  edu_pkg::edu_arch_type snap_reg;       // state at dispatch start
  edu_pkg::edu_arch_type task_reg;       // interrupted task state
  logic                  task_act_reg;   // handler task running
  edu_pkg::edu_gate_type gate_reg;       // fetched table entry
  logic [2:0]            idx_reg;        // frame slot index
  logic [63:0]           sp_reg;         // running stack pointer
  logic                  ss_en_reg;      // stack pair is pushed
  logic                  pchg_reg;       // privilege changes

  // mode decode
  wire real_mode = ctrl_reg[edu_pkg::CTRL_REAL_BIT];
  wire long_mode = ctrl_reg[edu_pkg::CTRL_LONG_BIT] & ~real_mode;
  wire idle      = (state_reg == ST_IDLE);

  // trap decode; arithmetic results never come here
  wire is_trap  = req.valid & (req.kind == edu_pkg::OP_TRAP);
  wire op_vcall = is_trap & (req.opcode == edu_pkg::OPC_VEC_CALL);
  wire op_ovf   = is_trap & (req.opcode == edu_pkg::OPC_OVF_TRAP)
                  & req.ovf;
  wire op_brk   = is_trap & (req.opcode == edu_pkg::OPC_BRK_CALL);
  wire op_dbg   = is_trap & (req.opcode == edu_pkg::OPC_DBG_CALL);

  // range check against the limits fetched by the decoder
  wire below    = $signed(req.operand) < $signed(req.lower);
  wire above    = $signed(req.operand) > $signed(req.upper);
  wire op_range = req.valid & (req.kind == edu_pkg::OP_RANGE)
                  & (below | above);

  // any of the six fp conditions, routed by instruction class
  wire op_fp    = req.valid & (req.kind == edu_pkg::OP_FP)
                  & (|req.fp_cond);
  wire [7:0] fp_vec = req.fp_packed ? edu_pkg::VEC_VECTOR_FP
                                    : edu_pkg::VEC_LEGACY_FP;

  // maskable interrupts from the pin, only with interrupts enabled
  wire ext_ok   = ext_intr & (ext_vector >= edu_pkg::VEC_MASK_MIN)
                  & arch.flags[edu_pkg::FLAGS_IF_BIT];

  wire op_ret   = req.valid & (req.kind == edu_pkg::OP_RETURN);
  wire op_frame = req.valid & (req.kind == edu_pkg::OP_FRAME);

  // software traps win over the pin in the same cycle
  wire sw_hit   = op_vcall | op_ovf | op_brk | op_dbg | op_range
                  | op_fp;
  wire start    = idle & (sw_hit | ext_ok);

  // vector selection
  wire [7:0] start_vec =
    op_vcall ? req.vector :
    op_ovf   ? edu_pkg::VEC_OVERFLOW :
    op_brk   ? edu_pkg::VEC_BREAK :
    op_dbg   ? edu_pkg::VEC_DEBUG :
    op_range ? edu_pkg::VEC_RANGE :
    op_fp    ? fp_vec : ext_vector;

  // table address: vector scaled by entry size of the mode
  wire [63:0] vec64  = {56'h0, vec_reg};
  wire [63:0] tbl_a  =
    real_mode ? (vec64 << edu_pkg::TBL_SH_REAL) :
    long_mode ? (vec64 << edu_pkg::TBL_SH_LONG) :
                (vec64 << edu_pkg::TBL_SH_PROT);

  // slot size and width mask per mode
  wire [3:0]  slot_b = real_mode ? edu_pkg::PUSH_REAL :
                       long_mode ? edu_pkg::PUSH_LONG :
                                   edu_pkg::PUSH_PROT;
  wire [63:0] mask   = real_mode ? 64'h0000_0000_0000_FFFF :
                       long_mode ? 64'hFFFF_FFFF_FFFF_FFFF :
                                   64'h0000_0000_FFFF_FFFF;

  // frame slots in push order: ss, sp, flags, cs, ip, error
  logic [63:0] slot_val;
  logic        slot_en;
  always_comb
  begin
    slot_val = 64'h0;
    slot_en  = 1'b0;
    case (idx_reg)
      3'd0:
      begin
        slot_val = {48'h0, snap_reg.ss};
        slot_en  = ss_en_reg;
      end
      3'd1:
      begin
        slot_val = snap_reg.sp;
        slot_en  = ss_en_reg;
      end
      3'd2:
      begin
        slot_val = {32'h0, snap_reg.flags};
        slot_en  = 1'b1;
      end
      3'd3:
      begin
        slot_val = {48'h0, snap_reg.cs};
        slot_en  = 1'b1;
      end
      3'd4:
      begin
        slot_val = snap_reg.ip;
        slot_en  = 1'b1;
      end
      3'd5:
      begin
        slot_val = {32'h0, err_reg};
        slot_en  = err_en_reg;
      end
      default:
      begin
        slot_val = 64'h0;
        slot_en  = 1'b0;
      end
    endcase
  end

  wire [63:0] slot_sp = sp_reg - {60'h0, slot_b};
  wire        last    = (idx_reg == 3'(edu_pkg::FRAME_SLOTS - 1));

  // handler entry state: new cs, ip, flags, stack
  logic [31:0] hflags;
  always_comb
  begin
    hflags = snap_reg.flags;
    // interrupt gates and real mode enter with interrupts off
    if ((gate_reg.kind == edu_pkg::GATE_INTR) | real_mode)
      hflags[edu_pkg::FLAGS_IF_BIT] = 1'b0;
  end
  wire [15:0] hss = (long_mode & pchg_reg) ? edu_pkg::NULL_SEL
                                           : snap_reg.ss;
  wire [63:0] hip = real_mode ? {48'h0, gate_reg.offset[15:0]}
                              : gate_reg.offset;

  // register read mux
  wire [31:0] status_w = {8'h0, vec_reg, 7'h0, task_act_reg,
                          1'b0, state_reg, 2'h0, ctrl_reg};
  wire [31:0] rd_mux   =
    (reg_addr == edu_pkg::REG_CTRL)   ? {30'h0, ctrl_reg} :
    (reg_addr == edu_pkg::REG_STATUS) ? status_w : 32'h0;

  // register port: control write, read data one cycle later
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg  <= edu_pkg::CTRL_RESET;
      reg_rdata <= 32'h0;
    end
    else
    begin
      if (reg_wr & (reg_addr == edu_pkg::REG_CTRL))
        ctrl_reg <= reg_wdata[1:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // frame setup: level cut to its low five bits, no privilege input
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_valid <= 1'b0;
      frame_sp    <= 64'h0;
      frame_level <= 5'h0;
    end
    else
    begin
      frame_valid <= op_frame & idle;
      if (op_frame & idle)
      begin
        frame_sp    <= arch.sp - {48'h0, req.storage};
        frame_level <= req.level[4:0];
      end
    end
  end

  // dispatch sequencer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg      <= ST_IDLE;
      vec_reg        <= 8'h0;
      err_en_reg     <= 1'b0;
      err_reg        <= 32'h0;
      snap_reg       <= '0;
      task_reg       <= '0;
      task_act_reg   <= 1'b0;
      gate_reg       <= '0;
      idx_reg        <= 3'h0;
      sp_reg         <= 64'h0;
      ss_en_reg      <= 1'b0;
      pchg_reg       <= 1'b0;
      ext_ack        <= 1'b0;
      busy           <= 1'b0;
      tbl_rd_en      <= 1'b0;
      tbl_rd_addr    <= 64'h0;
      push_en        <= 1'b0;
      push_addr      <= 64'h0;
      push_data      <= 64'h0;
      push_bytes     <= 4'h0;
      handler_valid  <= 1'b0;
      handler_state  <= '0;
      handler_code64 <= 1'b0;
      task_switch    <= 1'b0;
      task_restore   <= 1'b0;
      ret_valid      <= 1'b0;
    end
    else
    begin
      // pulses default low
      ext_ack       <= 1'b0;
      tbl_rd_en     <= 1'b0;
      push_en       <= 1'b0;
      handler_valid <= 1'b0;
      task_switch   <= 1'b0;
      task_restore  <= 1'b0;
      ret_valid     <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            // capture the interrupted state and the vector
            vec_reg    <= start_vec;
            err_en_reg <= op_range ? 1'b0 : (sw_hit & req.err_valid);
            err_reg    <= req.err_code;
            snap_reg   <= arch;
            sp_reg     <= arch.sp;
            ext_ack    <= ~sw_hit;
            busy       <= 1'b1;
            state_reg  <= ST_FETCH;
          end
          else if (op_ret)
          begin
            // return: handler task resumes the saved task
            ret_valid <= 1'b1;
            if (task_act_reg)
            begin
              task_restore  <= 1'b1;
              handler_state <= task_reg;
              task_act_reg  <= 1'b0;
            end
          end
        end
        ST_FETCH:
        begin
          tbl_rd_en   <= 1'b1;
          tbl_rd_addr <= tbl_a;
          state_reg   <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // entry arrives the cycle after the read
          if (!tbl_rd_en)
          begin
            gate_reg <= tbl_entry;
            pchg_reg <= (tbl_entry.priv != snap_reg.priv);
            ss_en_reg <= long_mode |
                         (~real_mode & (tbl_entry.priv != snap_reg.priv));
            idx_reg  <= 3'h0;
            if (~real_mode & (tbl_entry.kind == edu_pkg::GATE_TASK))
            begin
              // implicit task call into the handler task
              task_reg     <= snap_reg;
              task_act_reg <= 1'b1;
              task_switch  <= 1'b1;
              handler_state <= '{flags: snap_reg.flags,
                                 ip: tbl_entry.offset,
                                 cs: tbl_entry.sel,
                                 ss: snap_reg.ss,
                                 sp: snap_reg.sp,
                                 priv: tbl_entry.priv};
              busy      <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else
              state_reg <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          // one slot a cycle, zero-extended to the slot width
          if (slot_en)
          begin
            push_en    <= 1'b1;
            push_addr  <= slot_sp;
            push_data  <= slot_val & mask;
            push_bytes <= slot_b;
            sp_reg     <= slot_sp;
          end
          idx_reg <= idx_reg + 3'h1;
          if (last)
            state_reg <= ST_LOAD;
        end
        ST_LOAD:
        begin
          // far transfer into the handler
          handler_valid  <= 1'b1;
          handler_state  <= '{flags: hflags, ip: hip,
                              cs: real_mode ? gate_reg.offset[31:16]
                                            : gate_reg.sel,
                              ss: hss, sp: sp_reg,
                              priv: gate_reg.priv};
          handler_code64 <= long_mode;
          busy           <= 1'b0;
          state_reg      <= ST_IDLE;
        end
        default:
        begin
          busy      <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_ovf_no_trap: assert property (
    (idle && is_trap && req.opcode == edu_pkg::OPC_OVF_TRAP && !req.ovf
     && !req.err_valid && !ext_ok && req.kind == edu_pkg::OP_TRAP)
    |=> state_reg == ST_IDLE)
    else $error("overflow trap dispatched with flag clear");

  chk_brk_vector: assert property (
    (idle && op_brk) |=> (vec_reg == edu_pkg::VEC_BREAK) ##1 tbl_rd_en)
    else $error("breakpoint call did not fetch its vector");

  chk_range_vec: assert property (
    (idle && op_range && !op_fp) |=> vec_reg == edu_pkg::VEC_RANGE)
    else $error("range check did not select vector 5");

  chk_fp_route: assert property (
    (idle && op_fp && !is_trap) |=>
      vec_reg == ($past(req.fp_packed) ? edu_pkg::VEC_VECTOR_FP
                                       : edu_pkg::VEC_LEGACY_FP))
    else $error("fp condition routed to wrong vector");

  chk_push_long: assert property (
    (push_en && long_mode) |-> push_bytes == edu_pkg::PUSH_LONG)
    else $error("long mode push not eight bytes");

  chk_null_ss: assert property (
    (state_reg == ST_LOAD && long_mode && pchg_reg)
    |=> handler_valid && handler_state.ss == edu_pkg::NULL_SEL)
    else $error("stack selector not nulled on privilege change");

  chk_if_clear: assert property (
    (state_reg == ST_LOAD && gate_reg.kind == edu_pkg::GATE_INTR)
    |=> !handler_state.flags[edu_pkg::FLAGS_IF_BIT])
    else $error("interrupt gate left interrupts enabled");

  chk_real_index: assert property (
    (state_reg == ST_FETCH && real_mode)
    |=> tbl_rd_en && tbl_rd_addr == {54'h0, vec_reg, 2'h0})
    else $error("real mode table index wrong");

  chk_task_return: assert property (
    task_restore |-> $past(op_ret) && !task_act_reg)
    else $error("task restore without return");

  chk_frame_alloc: assert property (
    frame_valid |-> frame_sp == $past(arch.sp) - {48'h0, $past(req.storage)})
    else $error("frame reservation wrong");

endmodule
`default_nettype wire

// ===== tb/edu_tbl_model.sv
// table memory model that answers gate reads for the dispatch unit
`timescale 1ns/100ps
`default_nettype none
module edu_tbl_model (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  // read request and the gate kind to hand back
  input  wire logic                       tbl_rd_en,
  input  wire logic [63:0]                tbl_rd_addr,
  input  wire edu_pkg::edu_gate_kind_type kind_sel,
  // entry, valid only in the cycle after the read
  output edu_pkg::edu_gate_type           tbl_entry
);
  // entry follows the address; outside that cycle it toggles
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tbl_entry <= '0;
    else if (tbl_rd_en)
      tbl_entry <= {kind_sel, 16'h0008, 32'h0, ~tbl_rd_addr[15:0],
                    tbl_rd_addr[15:0] ^ 16'h1234, 2'h0};
    else
      tbl_entry <= ~tbl_entry;
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// bench: drives the dispatch unit and compares with its own model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // clock, reset and register port
  logic        sys_clk, reset_n, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  // request side, pin and state
  edu_pkg::edu_req_type       req, r;
  logic        ext_intr, ext_ack, busy, done;
  logic [7:0]  ext_vector, v;
  edu_pkg::edu_arch_type      arch, handler_state;
  edu_pkg::edu_gate_kind_type kind_sel;
  edu_pkg::edu_gate_type      tbl_entry;
  logic        tbl_rd_en, push_en, handler_valid, handler_code64;
  logic        task_switch, task_restore, ret_valid, frame_valid;
  logic [63:0] tbl_rd_addr, push_addr, push_data, frame_sp, ad, la, fsp, sv;
  logic [3:0]  push_bytes;
  logic [4:0]  frame_level, flv, seen;
  int          err_count, n_tests, mode, np;

  edu_dispatch edu_dispatch_i (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .req, .ext_intr, .ext_vector, .ext_ack,
    .busy, .arch, .tbl_rd_en, .tbl_rd_addr, .tbl_entry, .push_en, .push_addr,
    .push_data, .push_bytes, .handler_valid, .handler_state, .handler_code64,
    .task_switch, .task_restore, .ret_valid, .frame_valid, .frame_sp,
    .frame_level);
  edu_tbl_model edu_tbl_model_i (.sys_clk, .reset_n, .tbl_rd_en,
    .tbl_rd_addr, .kind_sel, .tbl_entry);

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // compare one value
  task automatic check(input logic [63:0] seen_v, input logic [63:0] exp);
    n_tests++;
    if (seen_v !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen_v, exp);
    end
  endtask

  // expected stack word of push n: ss, sp, flags, cs, ip, error
  function automatic logic [63:0] slot_exp(input int n);
    logic [63:0] w [6];
    int          k;
    w = '{{48'h0, arch.ss}, arch.sp, {32'h0, arch.flags},
          {48'h0, arch.cs}, arch.ip, {32'h0, r.err_code}};
    k = (mode == 2 || (mode == 0 && arch.priv != 2'h0)) ? n : n + 2;
    return w[k] & (mode == 1 ? 64'hFFFF : mode == 2 ? '1 : 64'hFFFF_FFFF);
  endfunction

  // verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // register port cycles
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd = reg_rdata;
  endtask

  // one request (ev: vector, -1 refused, -2 no table), then watch
  task automatic fire(input logic ext, input int ev, input int extra);
    @(posedge sys_clk);
    if (ext)
      ext_intr <= 1'b1;
    else
      req <= r;
    @(posedge sys_clk);
    req.valid <= 1'b0;
    ext_intr <= 1'b0;
    seen = '0;
    done = 1'b0;
    np = 0;
    for (int i = 0; i < 20 && !done; i++)
    begin
      @(negedge sys_clk);
      if (tbl_rd_en)
        ad = tbl_rd_addr;
      if (push_en)
        check(push_addr, (np > 0 ? la : arch.sp) - push_bytes);
      if (push_en)
        check(push_data, slot_exp(np));
      if (push_en && mode == 2 && np == 0)
        check(push_data[63:16], 0);
      if (push_en)
        check(push_bytes, mode == 1 ? 2 : mode == 2 ? 8 : 4);
      if (push_en)
        la = push_addr;
      np += push_en;
      if (frame_valid)
        fsp = frame_sp;
      if (frame_valid)
        flv = frame_level;
      seen |= {tbl_rd_en, handler_valid, task_switch, task_restore, ext_ack};
      done = handler_valid | task_switch | ret_valid | frame_valid;
    end
    check(done, ev != -1);
    check(seen[4], ev >= 0);
    check(np, ev < 0 || seen[2] ? 0 : (mode == 2 ? 5 : 3) + extra);
    if (ev >= 0)
      check(ad, ev << (mode == 1 ? 2 : mode == 2 ? 4 : 3));
    check(seen[2], ev >= 0 && kind_sel == edu_pkg::GATE_TASK && mode != 1);
    if (seen[3])
      check(handler_code64, mode == 2);
    if (seen[3])
      check(handler_state.flags[9], mode != 1 && kind_sel == 1);
    if (seen[3] && mode == 1)
      check(handler_state.ip, {48'h0, ad[15:0] ^ 16'h1234});
    if (seen[3] && mode == 1)
      check(handler_state.cs, {48'h0, ~ad[15:0]});
    // hand back right after a rising edge
    @(posedge sys_clk);
  endtask

  // explicit trap instruction
  task automatic trap(input logic [7:0] op, vec, input logic ovf,
                      input int ev, extra);
    r = '0;
    r.valid = 1'b1;
    r.kind = edu_pkg::OP_TRAP;
    r.opcode = op;
    r.vector = vec;
    r.ovf = ovf;
    r.err_valid = extra[0];
    r.err_code = $urandom;
    fire(1'b0, ev, extra);
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h7278));
    {reset_n, reg_wr, reg_rd, ext_intr, reg_addr, reg_wdata, ext_vector} = '0;
    {req, r, err_count, n_tests, mode} = '0;
    kind_sel = edu_pkg::GATE_INTR;
    arch = {32'h200 | $urandom, {$urandom, $urandom}, 16'h8, 16'h10,
            {$urandom, $urandom}, 2'h0};
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    // register reset value, read-only status, unmapped place
    reg_read(edu_pkg::REG_CTRL);
    check(rd, edu_pkg::CTRL_RESET);
    reg_write(edu_pkg::REG_CTRL, 32'h3);
    reg_write(edu_pkg::REG_STATUS, 32'h0);
    reg_read(edu_pkg::REG_STATUS);
    check(rd[1:0], 2'h3);
    reg_read(4'h8);
    check(rd, 0);
    // traps, range checks and fp classes in each mode
    for (int m = 0; m < 3; m++)
    begin
      mode = m;
      reg_write(edu_pkg::REG_CTRL, m);
      kind_sel <= m == 0 ? edu_pkg::GATE_TRAP : edu_pkg::GATE_INTR;
      v = $urandom_range(255, 32);
      trap(edu_pkg::OPC_VEC_CALL, v, 1'b0, v, 0);
      trap(edu_pkg::OPC_VEC_CALL, 8'h04, 1'b0, 4, 0);
      trap(edu_pkg::OPC_VEC_CALL, 8'h05, 1'b0, 5, 1);
      trap(edu_pkg::OPC_OVF_TRAP, 8'h00, 1'b0, -1, 0);
      trap(edu_pkg::OPC_OVF_TRAP, 8'h00, 1'b1, 4, 0);
      trap(edu_pkg::OPC_BRK_CALL, 8'h00, 1'b1, 3, 0);
      trap(edu_pkg::OPC_DBG_CALL, 8'h00, 1'b0, 1, 0);
      for (int k = 0; k < 9; k++)
      begin
        r = '0;
        r.valid = 1'b1;
        r.kind = k < 3 ? edu_pkg::OP_RANGE : edu_pkg::OP_FP;
        r.lower = 32'h10;
        r.upper = 32'h20;
        r.operand = k == 0 ? 32'h15 : k == 1 ? 32'h21 : 32'hFFFF_FFF0;
        r.fp_cond = k > 2 ? 6'h01 << (k - 3) : 6'h00;
        r.fp_packed = k[0];
        fire(1'b0, k == 0 ? -1 : k < 3 ? 5 : k[0] ? 19 : 16, 0);
      end
    end
    // long mode with a change of privilege
    arch.priv <= 2'h3;
    trap(edu_pkg::OPC_BRK_CALL, 8'h00, 1'b0, 3, 0);
    check(handler_state.ss, edu_pkg::NULL_SEL);
    arch.priv <= 2'h0;
    // pin requests in protected mode: masked, low vector, taken
    mode = 0;
    reg_write(edu_pkg::REG_CTRL, 0);
    arch.flags[9] <= 1'b0;
    ext_vector <= 8'h28;
    fire(1'b1, -1, 0);
    arch.flags[9] <= 1'b1;
    ext_vector <= 8'h1F;
    fire(1'b1, -1, 0);
    ext_vector <= 8'hC8;
    fire(1'b1, 8'hC8, 0);
    check(seen[0], 1);
    // task gate, then return restores the saved state
    kind_sel <= edu_pkg::GATE_TASK;
    trap(edu_pkg::OPC_BRK_CALL, 8'h00, 1'b0, 3, 0);
    sv = arch.ip;
    arch.ip <= {$urandom, $urandom};
    r = '0;
    r.valid = 1'b1;
    r.kind = edu_pkg::OP_RETURN;
    fire(1'b0, -2, 0);
    check(seen[1], 1);
    check(handler_state.ip, sv);
    // frame setup at an odd privilege
    arch.priv <= 2'h3;
    r.kind = edu_pkg::OP_FRAME;
    r.storage = $urandom;
    r.level = $urandom_range(31, 0);
    fire(1'b0, -2, 0);
    check(fsp, arch.sp - r.storage);
    check(flv, r.level[4:0]);
    tally_and_finish;
  end

  // watchdog: the run needs under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
